// File: irq_prio_map.svh
`ifndef IRQ_PRIO_MAP_SVH
`define IRQ_PRIO_MAP_SVH

// register indices on the plain port
`define PRIO_THREE_ADDR 3'h0
`define PRIO_FOUR_ADDR 3'h1
`define PRIO_FIVE_ADDR 3'h2
`define PRIO_SIX_ADDR 3'h3
`define PRIO_SEVEN_ADDR 3'h4
`define PRIO_STATUS_ADDR 3'h5

// field positions (low bit of each 3-bit field)
`define FIELD_HI_POS 12
`define FIELD_MH_POS 8
`define FIELD_ML_POS 4
`define FIELD_LO_POS 0

// per-register masks of implemented bits
`define PRIO_THREE_MASK 16'h0777
`define PRIO_FOUR_MASK 16'h7077
`define PRIO_FULL_MASK 16'h7777

// reset value of every implemented field: level 4
`define FIELD_RESET 3'h4
`define PRIO_THREE_RESET 16'h0444
`define PRIO_FOUR_RESET 16'h4044
`define PRIO_FULL_RESET 16'h4444

// codes
`define LEVEL_OFF 3'h0
`define LEVEL_MIN 3'h1
`define LEVEL_MAX 3'h7

`endif

// File: irq_prio_pkg.sv
package irq_prio_pkg;
    typedef logic [2:0] level_t;
    typedef logic [4:0] source_t;
    typedef logic [15:0] word_t;
    localparam int unsigned NUM_SOURCES = 18;
endpackage

// File: prio_field_reg.sv
`timescale 1ns/100ps
`include "irq_prio_map.svh"

// one 16-bit priority register with masked, write-ignoring storage
module prio_field_reg #(
    parameter logic [15:0] MASK = 16'h7777,
    parameter logic [15:0] RESET = 16'h4444
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // write side
    input wire logic wr_in,
    input wire logic [15:0] wdata_in,
    // stored value
    output logic [15:0] value_out
);
    logic [15:0] value_reg;

    // unimplemented bits never store, so they always read zero
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            value_reg <= RESET & MASK;
        else if (wr_in)
            value_reg <= wdata_in & MASK;
    end

    assign value_out = value_reg;
endmodule

// File: prio_arbiter.sv
`timescale 1ns/100ps

// picks highest nonzero level among pending enabled sources
module prio_arbiter (
    // per-source inputs
    input wire logic [17:0] req_in,
    input wire logic [53:0] levels_in,
    // winner
    output logic valid_out,
    output logic [4:0] id_out,
    output logic [2:0] level_out
);
    // lowest index wins ties; level zero never wins
    always_comb
    begin
        logic [2:0] lv;
        lv = 3'h0;
        valid_out = 1'b0;
        id_out = 5'h00;
        level_out = 3'h0;
        for (int i = 0; i < 18; i++)
        begin
            lv = levels_in[i*3 +: 3];
            if (req_in[i] && (lv > level_out))
            begin
                valid_out = 1'b1;
                id_out = 5'(i);
                level_out = lv;
            end
        end
    end
endmodule

// File: irq_prio_top.sv
`timescale 1ns/100ps
`include "irq_prio_map.svh"

// Behaviour
// - each source's priority field is three bits; 111 is level 7, highest
// - code 001 is level 1, lowest active; others map to their level
// - code 000 disables the source; it never requests the processor
// - unimplemented bits always read zero
// - every field resets to 100, level 4
// - register three: dma1 10-8, converter1 6-4, serial1 tx 2-0
// - register four: pin change 14-12, twowire master 6-4, slave 2-0
// - register five: capture8, capture7, converter2, ext irq1 high to low
// - register seven: serial2 tx, serial2 rx, ext irq2, timer5 high to low
module irq_prio_top (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    // register port
    input wire logic [2:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [15:0] RDATA_OUT,
    // request sources, pending and enabled, source order per level list
    input wire logic [17:0] REQ_IN,
    // request to processor
    output logic IRQ_OUT,
    output logic [4:0] IRQ_ID_OUT,
    output logic [2:0] IRQ_LEVEL_OUT,
    // per-source levels for downstream arbitration
    output logic [53:0] LEVELS_OUT
);
    localparam logic [15:0] MASKS [5] = '{`PRIO_THREE_MASK, `PRIO_FOUR_MASK,
        `PRIO_FULL_MASK, `PRIO_FULL_MASK, `PRIO_FULL_MASK};
    localparam logic [15:0] RESETS [5] = '{`PRIO_THREE_RESET, `PRIO_FOUR_RESET,
        `PRIO_FULL_RESET, `PRIO_FULL_RESET, `PRIO_FULL_RESET};

    irq_prio_pkg::word_t regs [5];
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic irq_reg;
    logic [4:0] id_reg;
    logic [2:0] level_reg;
    logic win_valid;
    logic [4:0] win_id;
    logic [2:0] win_level;
    logic [53:0] levels;
    logic [5:0] wr_sel;

    // decode of register index, used by the write path only; the read mux decodes ADDR_IN itself
    function automatic logic [5:0] sel_of(input logic [2:0] a);
        logic [5:0] s;
        s = 6'h00;
        if (a <= `PRIO_STATUS_ADDR)
            s[a] = 1'b1;
        return s;
    endfunction

    // one decode shared by all five write enables
    assign wr_sel = sel_of(ADDR_IN);

    // five priority registers, masked storage
    generate
        for (genvar g = 0; g < 5; g++)
        begin : g_reg
            prio_field_reg #(.MASK(MASKS[g]), .RESET(RESETS[g])) u_reg (
                .clk_in(CLK_IN),
                .nrst_in(NRST_IN),
                .wr_in(WR_IN && wr_sel[g]),
                .wdata_in(WDATA_IN),
                .value_out(regs[g])
            );
        end
    endgenerate

    // field placement per register
    assign levels[0*3 +: 3] = regs[0][`FIELD_MH_POS +: 3]; // dma_ch1_done_level
    assign levels[1*3 +: 3] = regs[0][`FIELD_ML_POS +: 3]; // converter1_done_level
    assign levels[2*3 +: 3] = regs[0][`FIELD_LO_POS +: 3]; // serial1_tx_level
    assign levels[3*3 +: 3] = regs[1][`FIELD_HI_POS +: 3]; // pin_change_level
    assign levels[4*3 +: 3] = regs[1][`FIELD_ML_POS +: 3]; // twowire1_master_level
    assign levels[5*3 +: 3] = regs[1][`FIELD_LO_POS +: 3]; // twowire1_slave_level
    assign levels[6*3 +: 3] = regs[2][`FIELD_HI_POS +: 3]; // capture8_level
    assign levels[7*3 +: 3] = regs[2][`FIELD_MH_POS +: 3]; // capture7_level
    assign levels[8*3 +: 3] = regs[2][`FIELD_ML_POS +: 3]; // converter2_done_level
    assign levels[9*3 +: 3] = regs[2][`FIELD_LO_POS +: 3]; // ext_irq1_level
    assign levels[10*3 +: 3] = regs[3][`FIELD_HI_POS +: 3]; // timer_four_level
    assign levels[11*3 +: 3] = regs[3][`FIELD_MH_POS +: 3]; // compare4_level
    assign levels[12*3 +: 3] = regs[3][`FIELD_ML_POS +: 3]; // compare3_level
    assign levels[13*3 +: 3] = regs[3][`FIELD_LO_POS +: 3]; // dma_ch2_done_level
    assign levels[14*3 +: 3] = regs[4][`FIELD_HI_POS +: 3]; // serial2_tx_level
    assign levels[15*3 +: 3] = regs[4][`FIELD_MH_POS +: 3]; // serial2_rx_level
    assign levels[16*3 +: 3] = regs[4][`FIELD_ML_POS +: 3]; // ext_irq2_level
    assign levels[17*3 +: 3] = regs[4][`FIELD_LO_POS +: 3]; // timer_five_level
    assign LEVELS_OUT = levels;

    // highest nonzero level wins; 000 never wins
    prio_arbiter u_arb (
        .req_in(REQ_IN),
        .levels_in(levels),
        .valid_out(win_valid),
        .id_out(win_id),
        .level_out(win_level)
    );

    // registered request output, one cycle behind the inputs
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
        begin
            irq_reg <= 1'b0;
            id_reg <= 5'h00;
            level_reg <= 3'h0;
        end
        else
        begin
            irq_reg <= win_valid;
            id_reg <= win_id;
            level_reg <= win_level;
        end
    end

    assign IRQ_OUT = irq_reg;
    assign IRQ_ID_OUT = id_reg;
    assign IRQ_LEVEL_OUT = level_reg;

    // read mux; stored zeros give zero unimplemented bits
    always_comb
    begin
        rdata_next = 16'h0000;
        case (ADDR_IN)
            `PRIO_THREE_ADDR: rdata_next = regs[0];
            `PRIO_FOUR_ADDR: rdata_next = regs[1];
            `PRIO_FIVE_ADDR: rdata_next = regs[2];
            `PRIO_SIX_ADDR: rdata_next = regs[3];
            `PRIO_SEVEN_ADDR: rdata_next = regs[4];
            `PRIO_STATUS_ADDR: rdata_next = {7'h00, irq_reg, id_reg, level_reg};
            default: rdata_next = 16'h0000;
        endcase
    end

    // read data valid only in cycle after strobe, zero otherwise
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
            rdata_reg <= 16'h0000;
        else if (RD_IN)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= 16'h0000;
    end

    assign RDATA_OUT = rdata_reg;

    // assertions
    property p_reset_level;
        @(posedge CLK_IN) $rose(NRST_IN) |-> (regs[2] == 16'h4444 && regs[0] == 16'h0444);
    endproperty
    a_reset_level: assert property (p_reset_level)
        else $error("fields not level 4 after reset");

    property p_unimpl_zero;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        RD_IN && ADDR_IN == `PRIO_THREE_ADDR |=> (RDATA_OUT & 16'hF888) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bit read one");

    property p_write_mask;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        WR_IN && ADDR_IN == `PRIO_FOUR_ADDR |=> regs[1] == ($past(WDATA_IN) & 16'h7077);
    endproperty
    a_write_mask: assert property (p_write_mask)
        else $error("write not masked");

    property p_readback;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        RD_IN && ADDR_IN == `PRIO_SIX_ADDR |=> RDATA_OUT == $past(regs[3]);
    endproperty
    a_readback: assert property (p_readback)
        else $error("readback mismatch");

    property p_disabled;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        IRQ_OUT |-> IRQ_LEVEL_OUT != 3'h0;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("level zero source requested");

    property p_no_req;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        REQ_IN == 18'h00000 |=> !IRQ_OUT;
    endproperty
    a_no_req: assert property (p_no_req)
        else $error("request without source");

    property p_highest;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        REQ_IN[0] && levels[2:0] == 3'h7 |=> IRQ_OUT && IRQ_LEVEL_OUT == 3'h7;
    endproperty
    a_highest: assert property (p_highest)
        else $error("level 7 not presented");

    property p_min_level;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        REQ_IN == 18'h00001 && levels[2:0] == 3'h1
            |=> IRQ_OUT && IRQ_ID_OUT == 5'h00 && IRQ_LEVEL_OUT == 3'h1;
    endproperty
    a_min_level: assert property (p_min_level)
        else $error("level 1 not presented");

    property p_field_map;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        levels[3*3 +: 3] == regs[1][14:12] && levels[14*3 +: 3] == regs[4][14:12];
    endproperty
    a_field_map: assert property (p_field_map)
        else $error("field placement wrong");

    // every source switched off: pending requests must stay silent
    property p_off_silent;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        REQ_IN != 18'h00000 && LEVELS_OUT == 54'h0 |=> !IRQ_OUT;
    endproperty
    a_off_silent: assert property (p_off_silent)
        else $error("disabled source requested");

    // each source's slice of the level bus against fixed register bits
    property p_place_three;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        LEVELS_OUT[2:0] == regs[0][10:8]
            && LEVELS_OUT[5:3] == regs[0][6:4]
            && LEVELS_OUT[8:6] == regs[0][2:0];
    endproperty
    a_place_three: assert property (p_place_three)
        else $error("register three field misplaced");

    property p_place_four;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        LEVELS_OUT[11:9] == regs[1][14:12]
            && LEVELS_OUT[14:12] == regs[1][6:4]
            && LEVELS_OUT[17:15] == regs[1][2:0];
    endproperty
    a_place_four: assert property (p_place_four)
        else $error("register four field misplaced");

    property p_place_five;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        LEVELS_OUT[20:18] == regs[2][14:12]
            && LEVELS_OUT[23:21] == regs[2][10:8]
            && LEVELS_OUT[26:24] == regs[2][6:4]
            && LEVELS_OUT[29:27] == regs[2][2:0];
    endproperty
    a_place_five: assert property (p_place_five)
        else $error("register five field misplaced");

    property p_place_six;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        LEVELS_OUT[32:30] == regs[3][14:12]
            && LEVELS_OUT[35:33] == regs[3][10:8]
            && LEVELS_OUT[38:36] == regs[3][6:4]
            && LEVELS_OUT[41:39] == regs[3][2:0];
    endproperty
    a_place_six: assert property (p_place_six)
        else $error("register six field misplaced");

    property p_place_seven;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        LEVELS_OUT[44:42] == regs[4][14:12]
            && LEVELS_OUT[47:45] == regs[4][10:8]
            && LEVELS_OUT[50:48] == regs[4][6:4]
            && LEVELS_OUT[53:51] == regs[4][2:0];
    endproperty
    a_place_seven: assert property (p_place_seven)
        else $error("register seven field misplaced");

    // status and unmapped indices hold no storage; a write must move no level
    property p_status_ro;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        WR_IN && ADDR_IN >= `PRIO_STATUS_ADDR |=> $stable(LEVELS_OUT);
    endproperty
    a_status_ro: assert property (p_status_ro)
        else $error("write to read-only index took effect");

    property p_rdata_idle;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        !RD_IN |=> RDATA_OUT == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without a read");

    property p_status_read;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        RD_IN && ADDR_IN == `PRIO_STATUS_ADDR
            |=> RDATA_OUT == {7'h00, $past(IRQ_OUT), $past(IRQ_ID_OUT), $past(IRQ_LEVEL_OUT)};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read differs from request outputs");

    property p_tie_low;
        @(posedge CLK_IN) disable iff (!NRST_IN)
        REQ_IN == 18'h3FFFF && LEVELS_OUT == {18{`LEVEL_MAX}} |=> IRQ_ID_OUT == 5'h00;
    endproperty
    a_tie_low: assert property (p_tie_low)
        else $error("tie not won by lowest source");

    // per-register checks, so a fault in any one register is caught
    generate
        for (genvar c = 0; c < 5; c++)
        begin : g_check
            property p_reset_each;
                @(posedge CLK_IN) $rose(NRST_IN) |-> regs[c] == RESETS[c];
            endproperty
            a_reset_each: assert property (p_reset_each)
                else $error("register not at reset value");

            property p_write_each;
                @(posedge CLK_IN) disable iff (!NRST_IN)
                WR_IN && ADDR_IN == 3'(c) |=> regs[c] == ($past(WDATA_IN) & MASKS[c]);
            endproperty
            a_write_each: assert property (p_write_each)
                else $error("register write lost or unmasked");

            property p_read_each;
                @(posedge CLK_IN) disable iff (!NRST_IN)
                RD_IN && ADDR_IN == 3'(c) |=> RDATA_OUT == $past(regs[c]);
            endproperty
            a_read_each: assert property (p_read_each)
                else $error("register read differs from contents");

            property p_zero_each;
                @(posedge CLK_IN) disable iff (!NRST_IN)
                RD_IN && ADDR_IN == 3'(c) |=> (RDATA_OUT & ~MASKS[c]) == 16'h0000;
            endproperty
            a_zero_each: assert property (p_zero_each)
                else $error("unimplemented bit read one");
        end
    endgenerate

    // main scenarios the bench should reach
    c_write: cover property (@(posedge CLK_IN) WR_IN ##1 RD_IN);
    c_irq: cover property (@(posedge CLK_IN) IRQ_OUT && IRQ_LEVEL_OUT == 3'h7);
    c_disable: cover property (@(posedge CLK_IN) REQ_IN != 18'h00000 ##1 !IRQ_OUT);
    c_tie: cover property (@(posedge CLK_IN) (REQ_IN == 18'h3FFFF) ##1 IRQ_OUT);
    c_second_reset: cover property (@(posedge CLK_IN) $rose(NRST_IN) ##1 RD_IN);
endmodule

// File: irq_prio_top_bench.sv
`timescale 1ns/100ps
`include "irq_prio_map.svh"

module irq_prio_top_bench;
    // stimulus and observed outputs
    logic CLK_IN = 1'b0;
    logic NRST_IN = 1'b0;
    logic [2:0] ADDR_IN = 3'h0;
    logic [15:0] WDATA_IN = 16'h0000;
    logic WR_IN = 1'b0;
    logic RD_IN = 1'b0;
    logic [17:0] REQ_IN = 18'h00000;
    logic [15:0] RDATA_OUT;
    logic IRQ_OUT;
    logic [4:0] IRQ_ID_OUT;
    logic [2:0] IRQ_LEVEL_OUT;
    logic [53:0] LEVELS_OUT;
    int bad_count = 0;
    int checked = 0;
    // expected contents, kept in step with every write the bench makes
    irq_prio_pkg::word_t rstv [5] = '{`PRIO_THREE_RESET, `PRIO_FOUR_RESET,
        `PRIO_FULL_RESET, `PRIO_FULL_RESET, `PRIO_FULL_RESET};
    irq_prio_pkg::word_t masks [5] = '{`PRIO_THREE_MASK, `PRIO_FOUR_MASK,
        `PRIO_FULL_MASK, `PRIO_FULL_MASK, `PRIO_FULL_MASK};
    irq_prio_pkg::word_t regv [5];
    // register index and low bit of each source's field, in source order
    int src_reg [18] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4};
    int src_pos [18] = '{8, 4, 0, 12, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0};

    // 250 MHz clock
    always #2 CLK_IN = ~CLK_IN;

    irq_prio_top irq_prio_top_inst (
        .CLK_IN(CLK_IN),
        .NRST_IN(NRST_IN),
        .ADDR_IN(ADDR_IN),
        .WDATA_IN(WDATA_IN),
        .WR_IN(WR_IN),
        .RD_IN(RD_IN),
        .RDATA_OUT(RDATA_OUT),
        .REQ_IN(REQ_IN),
        .IRQ_OUT(IRQ_OUT),
        .IRQ_ID_OUT(IRQ_ID_OUT),
        .IRQ_LEVEL_OUT(IRQ_LEVEL_OUT),
        .LEVELS_OUT(LEVELS_OUT)
    );

    task automatic check(input logic [53:0] seen, input logic [53:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    function automatic logic [2:0] lvl(input int i);
        return regv[src_reg[i]][src_pos[i] +: 3];
    endfunction

    // strobe stays up until the next access lowers it, so writes chain
    task automatic write_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge CLK_IN);
        WR_IN <= 1'b1;
        RD_IN <= 1'b0;
        ADDR_IN <= a;
        WDATA_IN <= d;
        if (a < 3'h5)
            regv[a] = d & masks[a];
    endtask

    // data looked at in the one cycle it stands, then must fall to zero
    task automatic read_reg(input logic [2:0] a, input logic [15:0] exp, input string what);
        @(posedge CLK_IN);
        WR_IN <= 1'b0;
        RD_IN <= 1'b1;
        ADDR_IN <= a;
        @(posedge CLK_IN);
        RD_IN <= 1'b0;
        @(negedge CLK_IN);
        check(RDATA_OUT, exp, what);
        @(negedge CLK_IN);
        check(RDATA_OUT, 16'h0000, "read data after its cycle");
    endtask

    task automatic levels_check(input string what);
        @(posedge CLK_IN);
        WR_IN <= 1'b0;
        RD_IN <= 1'b0;
        @(negedge CLK_IN);
        for (int i = 0; i < 18; i++)
            check(LEVELS_OUT[3*i +: 3], lvl(i), what);
    endtask

    // reference pick: highest nonzero level, lowest index on a tie
    task automatic irq_case(input logic [17:0] r);
        logic [2:0] best;
        logic [4:0] id;
        best = 3'h0;
        id = 5'h00;
        for (int i = 0; i < 18; i++)
            if (r[i] && lvl(i) > best)
            begin
                best = lvl(i);
                id = 5'(i);
            end
        @(posedge CLK_IN);
        WR_IN <= 1'b0;
        RD_IN <= 1'b0;
        REQ_IN <= r;
        @(posedge CLK_IN);
        @(negedge CLK_IN);
        check(IRQ_OUT, best != 3'h0, "request present");
        check(IRQ_LEVEL_OUT, best, "winning level");
        if (best != 3'h0)
        begin
            check(IRQ_ID_OUT, id, "winning source");
            read_reg(`PRIO_STATUS_ADDR, {7'h00, 1'b1, id, best}, "status");
        end
    endtask

    task automatic test_reset();
        for (int a = 0; a < 5; a++)
            read_reg(3'(a), rstv[a], "reset value");
        read_reg(3'h6, 16'h0000, "unmapped index");
        levels_check("reset level");
        $display("test reset done");
    endtask

    task automatic test_masks();
        for (int a = 0; a < 5; a++)
            write_reg(3'(a), 16'hFFFF);
        write_reg(3'h6, 16'hFFFF);
        write_reg(`PRIO_STATUS_ADDR, 16'hFFFF);
        for (int a = 0; a < 5; a++)
            read_reg(3'(a), masks[a], "implemented bits");
        read_reg(3'h6, 16'h0000, "unmapped index");
        levels_check("all level 7");
        irq_case(18'h3FFFF);
        irq_case(18'h00001);
        for (int a = 0; a < 5; a++)
        begin
            write_reg(3'(a), 16'h0000);
            read_reg(3'(a), 16'h0000, "cleared");
        end
        irq_case(18'h3FFFF);
        $display("test masks done");
    endtask

    task automatic test_map();
        irq_prio_pkg::word_t vals [5] = '{16'h0123, 16'h4056, 16'h7012, 16'h3456, 16'h7007};
        for (int a = 0; a < 5; a++)
            write_reg(3'(a), vals[a]);
        levels_check("field place");
        for (int a = 0; a < 5; a++)
            read_reg(3'(a), regv[a], "read back");
        $display("test map done");
    endtask

    task automatic test_arbitration();
        logic [17:0] pats [7] = '{18'h3FFFF, 18'h00080, 18'h00081, 18'h20010,
            18'h00C00, 18'h00001, 18'h00000};
        for (int p = 0; p < 7; p++)
            irq_case(pats[p]);
        $display("test arbitration done");
    endtask

    // reset again in mid-run with requests quiet
    task automatic test_second_reset();
        @(posedge CLK_IN);
        NRST_IN <= 1'b0;
        @(posedge CLK_IN);
        NRST_IN <= 1'b1;
        regv = rstv;
        for (int a = 0; a < 5; a++)
            read_reg(3'(a), rstv[a], "second reset");
        irq_case(18'h00008);
        $display("test second reset done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // main sequence
    initial
    begin
        regv = rstv;
        repeat (4) @(posedge CLK_IN);
        NRST_IN <= 1'b1;
        test_reset();
        test_masks();
        test_map();
        test_arbitration();
        test_second_reset();
        report_and_stop();
    end

    // hang guard, far beyond the fewer than two hundred cycles the run needs
    initial
    begin
        #200000;
        bad_count++;
        report_and_stop();
    end
endmodule
